// ---- core/seq_pkg.sv ----
// Package of types, register indices and default values for the default-state sequencer.
package seq_pkg;

  // Sequencer states of the configurable state machine plus the hand-off state.
  typedef enum logic [1:0] {
    ST_STANDBY  = 2'b00,
    ST_ACTIVE   = 2'b01,
    ST_SAFE     = 2'b10,
    ST_RECOVERY = 2'b11
  } fsm_state_t;

  // Sequence identifiers reported while a sequence runs.
  typedef enum logic [3:0] {
    SQ_NONE        = 4'h0,
    SQ_SEVERE      = 4'h1,
    SQ_GO_STANDBY  = 4'h2,
    SQ_GO_ACTIVE   = 4'h3,
    SQ_SPI_ON      = 4'h4,
    SQ_SPI_OFF     = 4'h5,
    SQ_CRC_ON      = 4'h6,
    SQ_CRC_OFF     = 4'h7,
    SQ_ALT_ADDR    = 4'h8,
    SQ_DEF_ADDR    = 4'h9
  } seq_id_t;

  // Interface settings that leave the block together.
  typedef struct packed {
    logic       spi_select;
    logic       primary_crc_enable;
    logic       secondary_crc_enable;
    logic [7:0] primary_target_address;
    logic [7:0] secondary_target_address;
  } iface_cfg_t;

  // Power stage controls that leave the block together.
  typedef struct packed {
    logic       clocks_stopped;
    logic       switching_stopped;
    logic       pulldown_enable;
    logic [8:0] rail_off;
  } power_ctl_t;

  localparam logic [4:0] NUM_RW = 5'h11;
  localparam logic [4:0] IDX_THERMAL_BUS = 5'h01;
  localparam logic [4:0] IDX_TK_BOOT = 5'h09;
  localparam logic [4:0] IDX_IF_SELECT = 5'h11;
  localparam logic [4:0] IDX_PRIMARY_ADDR = 5'h12;
  localparam logic [4:0] IDX_SECONDARY_ADDR = 5'h13;
  localparam logic [4:0] IDX_MD_IDENTITY = 5'h14;
  localparam logic [4:0] IDX_FOLLOWER_COUNT = 5'h15;

  // Reset values of the writable registers, index 0 in the low byte.
  localparam logic [135:0] RW_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1c, 8'h00,
    8'h00, 8'h00, 8'h0b, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};

  localparam int BIT_HS_PRIMARY = 2;
  localparam int BIT_HS_SECONDARY = 3;
  localparam int BIT_ILIM_TRIG = 4;
  localparam int BIT_SLEEP1_MASK = 5;
  localparam int BIT_SLEEP2_MASK = 6;
  localparam int BIT_QUICK_BIST = 2;

  localparam logic [7:0] ADDR_DEFAULT = 8'h28;
  localparam logic [7:0] ADDR_ALT = 8'h2c;
  localparam logic [7:0] ADDR_SECONDARY_DEFAULT = 8'h12;
  localparam logic [3:0] TARGET_ID_DEFAULT = 4'h5;
  localparam logic [3:0] MASTER_ID_DEFAULT = 4'h0;
  localparam logic [7:0] FOLLOWER_COUNT_DEFAULT = 8'h01;

  // Cycles a sequence spends on its register writes.
  localparam logic [2:0] SEQ_WRITE_CYCLES = 3'h4;
  // Rail turn-off delay in the severe sequence and its cycle count at 200 MHz.
  localparam int RAIL_OFF_DELAY_NS = 0;
  localparam int CLK_PERIOD_PS = 5000;
  localparam logic [2:0] RAIL_OFF_DELAY_CYC = 3'((RAIL_OFF_DELAY_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [8:0] ALL_RAILS = 9'h1ff;

endpackage : seq_pkg

// ---- core/default_sequencer.sv ----
// Default-configured power state sequencer with trigger table and sequences.
//
// Summary of operation
// RQ1: Three user states plus recovery hand-off.
// RQ2: Pending triggers resolved by fixed priority order.
// RQ3: Immediate shutdown goes safe, runs severe sequence.
// RQ4: Off request in active goes go_standby_sequence.
// RQ5: On request in standby goes go_active_sequence.
// RQ6: Interface pin edges turn SPI on/off.
// RQ7: CRC pin edges turn CRC checking on/off.
// RQ8: Address pin edges select address 2C/28.
// RQ9: Safe leaves unconditionally for hardware recovery.
// RQ10: Severe: stop clocks/switching, then rails off.
// RQ11: Other sequences never touch output rails.
// RQ12: Standby keeps resources down, awaits start-up.
// RQ13: Active keeps rails off, allows interface programming.
// RQ14: Quick self-test bit defaults to one.
// RQ15: Interface settings ignore writes; defaults fixed.
// RQ16: Unmasked sleep requests join transition decisions.
// RQ17: Current-limit events no trigger by default.
// RQ18: High-speed mode only after controller code; a software write to IDX_THERMAL_BUS can also set the flags.
// RQ19: Multi-device settings frozen after start-up.
// RQ20: Pin edges act only while active.
// RQ21: No new trigger while a sequence runs.
`timescale 1ns/1ps
`default_nettype none

module default_sequencer
(
  input  wire logic                CLK_SYS,
  input  wire logic                SRST,
  input  wire logic                IMM_SHUTDOWN,
  input  wire logic                OFF_REQUEST,
  input  wire logic                ON_REQUEST,
  input  wire logic                SLEEP_REQ_ONE_N,
  input  wire logic                SLEEP_REQ_TWO_N,
  input  wire logic                CURRENT_LIMIT_EVT,
  input  wire logic                INTERFACE_SELECT_PIN,
  input  wire logic                CRC_SELECT_PIN,
  input  wire logic                ADDRESS_SELECT_PIN,
  input  wire logic                HS_CODE_PRIMARY,
  input  wire logic                HS_CODE_SECONDARY,
  input  wire logic                STARTUP_DONE,
  input  wire logic                REPROG_STB,
  input  wire seq_pkg::iface_cfg_t REPROG_IFACE,
  input  wire logic [3:0]          REPROG_TARGET_ID,
  input  wire logic [7:0]          REPROG_FOLLOWERS,
  input  wire logic                CFG_WR_EN,
  input  wire logic [4:0]          CFG_INDEX,
  input  wire logic [7:0]          CFG_WDATA,
  output logic [7:0]               CFG_RDATA,
  output seq_pkg::fsm_state_t      STATE,
  output seq_pkg::seq_id_t         SEQ_ID,
  output logic                     SEQ_BUSY,
  output logic                     INTERNAL_ACTIVE,
  output logic                     RECOVERY_REQ,
  output seq_pkg::iface_cfg_t      IFACE,
  output seq_pkg::power_ctl_t      POWER,
  output logic                     QUICK_SELFTEST
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  fsm_state_t  state_q, state_d;
  seq_id_t     seq_q, seq_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [2:0]  lvl_q, lvl_d;
  logic [2:0]  pin_q;
  logic        active_q, active_d;
  iface_cfg_t  ifc_q, ifc_d;
  power_ctl_t  pwr_q, pwr_d;
  logic [135:0] rw_q, rw_d;
  logic [3:0]  tid_q, tid_d;
  logic [7:0]  fol_q, fol_d;
  logic [7:0]  rdata_d;
  logic        sleep_trig;
  logic        imm_trig;
  logic        off_trig;
  logic        idle;
  logic        busy_q, busy_d;
  logic        rec_q, rec_d;

  // Byte select from the flat register store.
  function automatic logic [7:0] rw_byte(input logic [135:0] v, input logic [4:0] i);
    logic [7:0] r;
    r = v[{i, 3'h0} +: 8];
    return r;
  endfunction : rw_byte

  ////////////////////////////////////////////////////////////////////////////
  // Trigger qualification.

  // Sleep requests count only while unmasked; a current-limit event is a trigger only when enabled.
  always_comb
  begin
    sleep_trig = (~SLEEP_REQ_ONE_N & ~rw_q[8 + BIT_SLEEP1_MASK])   // RQ16
               | (~SLEEP_REQ_TWO_N & ~rw_q[8 + BIT_SLEEP2_MASK]);  // RQ16
    imm_trig   = IMM_SHUTDOWN | (CURRENT_LIMIT_EVT & rw_q[8 + BIT_ILIM_TRIG]); // RQ17
    off_trig   = OFF_REQUEST | sleep_trig;
    idle       = (cnt_q == 3'h0); // RQ21
  end

  ////////////////////////////////////////////////////////////////////////////
  // State machine and sequences.

  // Picks the highest-priority pending trigger and starts its sequence.
  always_comb
  begin
    state_d  = state_q;
    seq_d    = seq_q;
    cnt_d    = cnt_q;
    lvl_d    = lvl_q;
    active_d = active_q;
    ifc_d    = ifc_q;
    pwr_d    = pwr_q; // RQ11
    if (cnt_q != 3'h0)
    begin
      cnt_d = cnt_q - 3'h1;
      if (cnt_q == 3'h1)
        seq_d = SQ_NONE;
    end
    // Severe sequence second step: rails off through pulldowns, no added delay.
    if (seq_q == SQ_SEVERE && pwr_q.clocks_stopped &&
        cnt_q == SEQ_WRITE_CYCLES - RAIL_OFF_DELAY_CYC)
    begin
      pwr_d.pulldown_enable = 1'b1; // RQ10
      pwr_d.rail_off        = ALL_RAILS; // RQ10
    end
    if (state_q != ST_ACTIVE)
      lvl_d = pin_q; // RQ20
    case (state_q)
      ST_STANDBY:
      begin
        if (idle && imm_trig)
        begin
          state_d  = ST_SAFE; // RQ3
          seq_d    = SQ_SEVERE;
          cnt_d    = SEQ_WRITE_CYCLES;
          pwr_d.clocks_stopped    = 1'b1; // RQ10
          pwr_d.switching_stopped = 1'b1; // RQ10
        end
        else if (idle && ON_REQUEST)
        begin
          state_d  = ST_ACTIVE; // RQ5
          seq_d    = SQ_GO_ACTIVE;
          cnt_d    = SEQ_WRITE_CYCLES;
          active_d = 1'b1; // RQ5
        end
      end
      ST_ACTIVE:
      begin
        if (!idle)
        begin
          state_d = ST_ACTIVE; // RQ21
        end
        else if (imm_trig) // RQ2
        begin
          state_d  = ST_SAFE; // RQ3
          seq_d    = SQ_SEVERE;
          cnt_d    = SEQ_WRITE_CYCLES;
          pwr_d.clocks_stopped    = 1'b1; // RQ10
          pwr_d.switching_stopped = 1'b1; // RQ10
        end
        else if (off_trig)
        begin
          state_d  = ST_STANDBY; // RQ4
          seq_d    = SQ_GO_STANDBY;
          cnt_d    = SEQ_WRITE_CYCLES;
          active_d = 1'b0; // RQ4
        end
        else if (pin_q[0] != lvl_q[0])
        begin
          lvl_d[0]         = pin_q[0];
          ifc_d.spi_select = pin_q[0]; // RQ6
          seq_d            = pin_q[0] ? SQ_SPI_ON : SQ_SPI_OFF;
          cnt_d            = SEQ_WRITE_CYCLES;
        end
        else if (pin_q[1] != lvl_q[1])
        begin
          lvl_d[1]                 = pin_q[1];
          ifc_d.primary_crc_enable   = pin_q[1]; // RQ7
          ifc_d.secondary_crc_enable = pin_q[1]; // RQ7
          seq_d                    = pin_q[1] ? SQ_CRC_ON : SQ_CRC_OFF;
          cnt_d                    = SEQ_WRITE_CYCLES;
        end
        else if (pin_q[2] != lvl_q[2])
        begin
          lvl_d[2]                     = pin_q[2];
          ifc_d.primary_target_address = pin_q[2] ? ADDR_ALT : ADDR_DEFAULT; // RQ8
          seq_d                        = pin_q[2] ? SQ_ALT_ADDR : SQ_DEF_ADDR;
          cnt_d                        = SEQ_WRITE_CYCLES;
        end
        else if (REPROG_STB)
        begin
          ifc_d = REPROG_IFACE; // RQ13
        end
      end
      ST_SAFE:
      begin
        if (idle)
        begin
          state_d = ST_RECOVERY; // RQ9
        end
      end
      ST_RECOVERY:
      begin
        state_d = ST_RECOVERY; // RQ1
      end
      default:
      begin
        state_d = ST_STANDBY;
      end
    endcase
    // Standby may take a reprogramming that leaves the interface as it is.
    if (state_q == ST_STANDBY && idle && REPROG_STB && REPROG_IFACE == ifc_q)
      ifc_d = REPROG_IFACE; // RQ12
    busy_d = (cnt_d != 3'h0); // RQ21
    rec_d  = (state_d == ST_RECOVERY); // RQ9
  end

  // Registers the sequencer state.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      state_q  <= ST_STANDBY; // RQ12
      seq_q    <= SQ_NONE;
      cnt_q    <= 3'h0;
      lvl_q    <= 3'h0;
      pin_q    <= 3'h0;
      active_q <= 1'b0;
      busy_q   <= 1'b0;
      rec_q    <= 1'b0;
      ifc_q    <= '{spi_select: 1'b0, primary_crc_enable: 1'b0,
                    secondary_crc_enable: 1'b0,
                    primary_target_address: ADDR_DEFAULT,
                    secondary_target_address: ADDR_SECONDARY_DEFAULT}; // RQ15
      pwr_q    <= '{clocks_stopped: 1'b0, switching_stopped: 1'b0,
                    pulldown_enable: 1'b0, rail_off: ALL_RAILS}; // RQ13
    end
    else
    begin
      state_q  <= state_d;
      seq_q    <= seq_d;
      cnt_q    <= cnt_d;
      lvl_q    <= lvl_d;
      pin_q    <= {ADDRESS_SELECT_PIN, CRC_SELECT_PIN, INTERFACE_SELECT_PIN};
      active_q <= active_d;
      busy_q   <= busy_d;
      rec_q    <= rec_d;
      ifc_q    <= ifc_d;
      pwr_q    <= pwr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  // Software writes reach writable registers only; fixed ones ignore them.
  always_comb
  begin
    rw_d    = rw_q;
    tid_d   = tid_q;
    fol_d   = fol_q;
    rdata_d = 8'h00;
    if (CFG_WR_EN && CFG_INDEX < NUM_RW)
      rw_d[{CFG_INDEX, 3'h0} +: 8] = CFG_WDATA; // RQ15
    // A controller code sets the high-speed flag; it wins over a clearing write.
    if (HS_CODE_PRIMARY)
      rw_d[8 + BIT_HS_PRIMARY] = 1'b1; // RQ18
    if (HS_CODE_SECONDARY)
      rw_d[8 + BIT_HS_SECONDARY] = 1'b1; // RQ18
    if (REPROG_STB && !STARTUP_DONE)
    begin
      tid_d = REPROG_TARGET_ID; // RQ19
      fol_d = REPROG_FOLLOWERS; // RQ19
    end
    if (CFG_INDEX < NUM_RW)
      rdata_d = rw_byte(rw_q, CFG_INDEX);
    else if (CFG_INDEX == IDX_IF_SELECT)
      rdata_d = {5'h00, ifc_q.secondary_crc_enable, ifc_q.primary_crc_enable,
                 ifc_q.spi_select};
    else if (CFG_INDEX == IDX_PRIMARY_ADDR)
      rdata_d = ifc_q.primary_target_address;
    else if (CFG_INDEX == IDX_SECONDARY_ADDR)
      rdata_d = ifc_q.secondary_target_address;
    else if (CFG_INDEX == IDX_MD_IDENTITY)
      rdata_d = {MASTER_ID_DEFAULT, tid_q};
    else if (CFG_INDEX == IDX_FOLLOWER_COUNT)
      rdata_d = fol_q;
  end

  // Registers the configuration store and read data.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      rw_q      <= RW_RESET; // RQ14
      tid_q     <= TARGET_ID_DEFAULT; // RQ19
      fol_q     <= FOLLOWER_COUNT_DEFAULT; // RQ19
      CFG_RDATA <= 8'h00;
    end
    else
    begin
      rw_q      <= rw_d;
      tid_q     <= tid_d;
      fol_q     <= fol_d;
      CFG_RDATA <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Outputs are the registered state.
  always_comb
  begin
    STATE           = state_q;
    SEQ_ID          = seq_q;
    SEQ_BUSY        = busy_q;
    INTERNAL_ACTIVE = active_q;
    RECOVERY_REQ    = rec_q; // RQ9
    IFACE           = ifc_q;
    POWER           = pwr_q;
    QUICK_SELFTEST  = rw_q[IDX_TK_BOOT * 8 + BIT_QUICK_BIST]; // RQ14
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_severe_entry;
    @(posedge CLK_SYS) disable iff (SRST)
    (state_q == ST_ACTIVE && idle && imm_trig) |=> (state_q == ST_SAFE && seq_q == SQ_SEVERE);
  endproperty
  a_severe_entry: assert property (p_severe_entry) else $error("no safe entry"); // RQ3

  property p_off_priority;
    @(posedge CLK_SYS) disable iff (SRST)
    (state_q == ST_ACTIVE && idle && !imm_trig && off_trig && ON_REQUEST)
      |=> state_q == ST_STANDBY;
  endproperty
  a_off_priority: assert property (p_off_priority) else $error("bad priority"); // RQ2

  property p_go_active;
    @(posedge CLK_SYS) disable iff (SRST)
    (state_q == ST_STANDBY && idle && !imm_trig && ON_REQUEST)
      |=> (state_q == ST_ACTIVE && INTERNAL_ACTIVE);
  endproperty
  a_go_active: assert property (p_go_active) else $error("no active entry"); // RQ5

  property p_safe_exit;
    @(posedge CLK_SYS) disable iff (SRST)
    $rose(state_q == ST_SAFE) |-> ##[1:5] RECOVERY_REQ;
  endproperty
  a_safe_exit: assert property (p_safe_exit) else $error("safe not left"); // RQ9

  property p_severe_order;
    @(posedge CLK_SYS) disable iff (SRST)
    $rose(POWER.pulldown_enable) |-> $past(POWER.clocks_stopped) && POWER.rail_off == ALL_RAILS;
  endproperty
  a_severe_order: assert property (p_severe_order) else $error("rails before clocks"); // RQ10

  property p_rails_untouched;
    @(posedge CLK_SYS) disable iff (SRST)
    (seq_q != SQ_SEVERE) |=> $stable(POWER) || seq_q == SQ_SEVERE;
  endproperty
  a_rails_untouched: assert property (p_rails_untouched) else $error("rail changed"); // RQ11

  property p_addr_alt;
    @(posedge CLK_SYS) disable iff (SRST)
    (state_q == ST_ACTIVE && idle && !imm_trig && !off_trig && pin_q[1:0] == lvl_q[1:0]
     && pin_q[2] && !lvl_q[2]) |=> IFACE.primary_target_address == ADDR_ALT;
  endproperty
  a_addr_alt: assert property (p_addr_alt) else $error("address not 2c"); // RQ8

  property p_busy_block;
    @(posedge CLK_SYS) disable iff (SRST)
    (SEQ_BUSY && state_q == ST_ACTIVE) |=> state_q == ST_ACTIVE;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("trigger while busy"); // RQ21

  property p_pins_idle_standby;
    @(posedge CLK_SYS) disable iff (SRST)
    (state_q == ST_STANDBY) |=> $stable(IFACE.spi_select) || $past(REPROG_STB);
  endproperty
  a_pins_idle_standby: assert property (p_pins_idle_standby) else $error("edge in standby"); // RQ20

  c_go_active: cover property (@(posedge CLK_SYS) disable iff (SRST) seq_q == SQ_GO_ACTIVE);
  c_spi_on: cover property (@(posedge CLK_SYS) disable iff (SRST) seq_q == SQ_SPI_ON);
  c_recovery: cover property (@(posedge CLK_SYS) disable iff (SRST) $rose(RECOVERY_REQ));

endmodule : default_sequencer

`default_nettype wire

// ---- tb/host_model.sv ----
// Host processor model that drives the sequencer's trigger pins, mode pins and register port.
`timescale 1ns/1ps
`default_nettype none

module host_model
(
  input  wire logic         clk,
  output logic              imm,
  output logic              off,
  output logic              on,
  output logic              ilim,
  output logic              hs1,
  output logic              hs2,
  output logic              slp1_n,
  output logic              slp2_n,
  output logic [2:0]        pins,
  output logic              sdone,
  output logic              rstb,
  output seq_pkg::iface_cfg_t rcfg,
  output logic [3:0]        rid,
  output logic [7:0]        rfol,
  output logic              wen,
  output logic [4:0]        idx,
  output logic [7:0]        wdat,
  input  wire logic [7:0]   rdat
);
  import seq_pkg::*;

  // Everything idles at time zero so that no sequencer input starts unknown.
  initial
  begin
    {slp2_n, slp1_n, hs2, hs1, ilim, on, off, imm} = 8'hc0;
    {pins, sdone, rstb, rcfg, rid, rfol, wen, idx, wdat} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mask bits: imm, off, on, ilim, hs1, hs2, sleep one, sleep two; sleeps are low.
  task automatic trig(input logic [7:0] m);
    @(posedge clk);
    {slp2_n, slp1_n, hs2, hs1, ilim, on, off, imm} <= m ^ 8'hc0;
    @(posedge clk);
    {slp2_n, slp1_n, hs2, hs1, ilim, on, off, imm} <= 8'hc0;
  endtask : trig

  // Mode pins are levels; the sequencer finds their edges itself.
  task automatic set_pins(input logic [2:0] v);
    @(posedge clk);
    pins <= v;
  endtask : set_pins

  // Start-up completion level that freezes the multi-device settings.
  task automatic set_done(input logic v);
    @(posedge clk);
    sdone <= v;
  endtask : set_done

  // One reprogramming strobe with its data held for the strobe cycle.
  task automatic reprog(input iface_cfg_t c, input logic [3:0] i, input logic [7:0] f);
    @(posedge clk);
    {rstb, rcfg, rid, rfol} <= {1'b1, c, i, f};
    @(posedge clk);
    rstb <= 1'b0;
  endtask : reprog

  // Register write of one cycle.
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    @(posedge clk);
    {wen, idx, wdat} <= {1'b1, i, d};
    @(posedge clk);
    wen <= 1'b0;
  endtask : wr

  // Register read; the data comes one edge after the index.
  task automatic rd(input logic [4:0] i, output logic [7:0] d);
    @(posedge clk);
    idx <= i;
    @(posedge clk);
    #1;
    d = rdat;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ---- tb/pmic_default_state_sequencer_tb.sv ----
// Self-checking testbench of the default-state sequencer.
`timescale 1ns/1ps
`default_nettype none

module pmic_default_state_sequencer_tb;
  import seq_pkg::*;
  localparam iface_cfg_t IF_DEF = {3'b000, ADDR_DEFAULT, ADDR_SECONDARY_DEFAULT};
  localparam iface_cfg_t IF_ALT = {3'b101, 8'h30, 8'h14};
  logic       clk_sys, srst, imm, off, on, ilim, hs1, hs2, slp1_n, slp2_n;
  logic       sdone, rstb, wen, busy, int_act, rec_req, qst;
  logic [2:0] pins, pv, pc;
  logic [3:0] rid, id;
  logic [4:0] idx;
  logic [7:0] rfol, wdat, rdat, d, v, fol;
  iface_cfg_t rcfg, iface;
  fsm_state_t state, s0;
  seq_id_t    seq_id;
  power_ctl_t power, p0;
  int         miscompares, check_count, i, k, f;

  // Free-running system clock and power-on reset.
  initial
  begin
    clk_sys = 1'b0;
    srst = 1'b1;
  end
  always #2.5 clk_sys = ~clk_sys;

  host_model host_model_inst (.clk(clk_sys), .imm(imm), .off(off), .on(on), .ilim(ilim),
    .hs1(hs1), .hs2(hs2), .slp1_n(slp1_n), .slp2_n(slp2_n), .pins(pins), .sdone(sdone),
    .rstb(rstb), .rcfg(rcfg), .rid(rid), .rfol(rfol), .wen(wen), .idx(idx), .wdat(wdat),
    .rdat(rdat));

  default_sequencer default_sequencer_inst (.CLK_SYS(clk_sys), .SRST(srst),
    .IMM_SHUTDOWN(imm), .OFF_REQUEST(off), .ON_REQUEST(on), .SLEEP_REQ_ONE_N(slp1_n),
    .SLEEP_REQ_TWO_N(slp2_n), .CURRENT_LIMIT_EVT(ilim), .INTERFACE_SELECT_PIN(pins[0]),
    .CRC_SELECT_PIN(pins[1]), .ADDRESS_SELECT_PIN(pins[2]), .HS_CODE_PRIMARY(hs1),
    .HS_CODE_SECONDARY(hs2), .STARTUP_DONE(sdone), .REPROG_STB(rstb), .REPROG_IFACE(rcfg),
    .REPROG_TARGET_ID(rid), .REPROG_FOLLOWERS(rfol), .CFG_WR_EN(wen), .CFG_INDEX(idx),
    .CFG_WDATA(wdat), .CFG_RDATA(rdat), .STATE(state), .SEQ_ID(seq_id), .SEQ_BUSY(busy),
    .INTERNAL_ACTIVE(int_act), .RECOVERY_REQ(rec_req), .IFACE(iface), .POWER(power),
    .QUICK_SELFTEST(qst));

  ////////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a difference at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Read-only and unmapped registers keep their defaults whatever is written.
  function automatic logic [7:0] ro_exp(input int n);
    case (n)
      18: return ADDR_DEFAULT;
      19: return ADDR_SECONDARY_DEFAULT;
      20: return {MASTER_ID_DEFAULT, TARGET_ID_DEFAULT};
      21: return FOLLOWER_COUNT_DEFAULT;
      default: return 8'h00;
    endcase
  endfunction : ro_exp

  // Sequence that a trigger mask starts with default masks and no immediate shutdown.
  function automatic seq_id_t exp_seq(input fsm_state_t s, input logic [7:0] m);
    if (s == ST_ACTIVE && (m[1] | m[6] | m[7]))
      return SQ_GO_STANDBY;
    if (s == ST_STANDBY && m[2])
      return SQ_GO_ACTIVE;
    return SQ_NONE;
  endfunction : exp_seq

  // Interface settings that follow from the three mode pin levels.
  function automatic iface_cfg_t exp_if(input logic [2:0] p);
    return {p[0], p[1], p[1], p[2] ? ADDR_ALT : ADDR_DEFAULT, ADDR_SECONDARY_DEFAULT};
  endfunction : exp_if

  // Waits for a sequence to start, checks its identity, then its length.
  task automatic seq_walk(input seq_id_t sid, output power_ctl_t pw);
    int n;
    int w;
    n = 0;
    w = 0;
    #1;
    while (busy !== 1'b1 && w < 6)
    begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    pw = power;
    chk(seq_id, sid);
    while (busy === 1'b1 && n < 9)
    begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    chk(32'(n), 32'(SEQ_WRITE_CYCLES));
  endtask : seq_walk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard: far beyond the fewer than one thousand cycles that the tests take.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end

  // Main sequence of scenarios.
  initial
  begin
    void'($urandom(43426));
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    wt(1);
    chk(state, ST_STANDBY);
    chk(qst, 1'b1);
    chk(iface, IF_DEF);
    chk(power, {3'b000, ALL_RAILS});
    for (i = 0; i < 17; i++)
    begin
      host_model_inst.rd(5'(i), d);
      chk(d, RW_RESET[i*8 +: 8]);
    end
    for (i = 17; i < 23; i++)
    begin
      host_model_inst.wr(5'(i), 8'($urandom));
      host_model_inst.rd(5'(i), d);
      chk(d, ro_exp(i));
    end
    for (i = 0; i < 17; i++)
    begin
      v = (i == 1) ? 8'h00 : 8'($urandom);
      host_model_inst.wr(5'(i), v);
      host_model_inst.rd(5'(i), d);
      chk(d, v);
      if (i == 9)
        chk(qst, v[BIT_QUICK_BIST]);
    end
    // Current limit and high-speed codes in standby.
    host_model_inst.trig(8'h38);
    wt(6);
    chk(state, ST_STANDBY);
    host_model_inst.rd(5'h01, d);
    chk(d, 8'h0c);
    // Reprogramming in standby, before and after start-up completes.
    id = 4'($urandom);
    fol = 8'($urandom);
    host_model_inst.reprog(IF_DEF, id, fol);
    host_model_inst.rd(5'h14, d);
    chk(d, {MASTER_ID_DEFAULT, id});
    host_model_inst.set_done(1'b1);
    host_model_inst.reprog(IF_ALT, ~id, ~fol);
    host_model_inst.rd(5'h15, d);
    chk(d, fol);
    chk(iface, IF_DEF);
    // Pin edges seen in standby are dropped.
    host_model_inst.set_pins(3'b111);
    wt(6);
    host_model_inst.set_pins(3'b000);
    wt(6);
    chk({iface, busy}, {IF_DEF, 1'b0});
    // Both sleep requests take the machine out of active.
    for (i = 6; i < 8; i++)
    begin
      host_model_inst.trig(8'h04);
      seq_walk(SQ_GO_ACTIVE, p0);
      chk({state, int_act}, {ST_ACTIVE, 1'b1});
      host_model_inst.trig(8'(1 << i));
      seq_walk(SQ_GO_STANDBY, p0);
      chk({state, int_act}, {ST_STANDBY, 1'b0});
    end
    // All three pins together in active: sequences run one after another.
    host_model_inst.trig(8'h04);
    seq_walk(SQ_GO_ACTIVE, p0);
    for (f = 0; f < 2; f++)
    begin
      host_model_inst.set_pins(f != 0 ? 3'b000 : 3'b111);
      for (k = 0; k < 3; k++)
        seq_walk(seq_id_t'(4 + 2 * k + f), p0);
      chk(iface.spi_select, f == 0);
      chk({iface.primary_crc_enable, iface.secondary_crc_enable}, f != 0 ? 0 : 3);
      chk(iface.primary_target_address, f != 0 ? ADDR_DEFAULT : ADDR_ALT);
      chk({state, power}, {ST_ACTIVE, 3'b000, ALL_RAILS});
    end
    // Random trigger masks and pin levels against the bench's own expectation.
    for (i = 0; i < 24; i++)
    begin
      v = 8'($urandom) & 8'hfe;
      s0 = state;
      host_model_inst.trig(v);
      if (exp_seq(s0, v) == SQ_NONE)
      begin
        wt(6);
        chk({state, busy}, {s0, 1'b0});
      end
      else
        seq_walk(exp_seq(s0, v), p0);
      if (state == ST_ACTIVE)
      begin
        pv = 3'($urandom);
        pc = pins;
        host_model_inst.set_pins(pv);
        for (k = 0; k < 3; k++)
          if (pv[k] != pc[k])
            seq_walk(seq_id_t'(4 + 2 * k + (pv[k] ? 0 : 1)), p0);
        chk(iface, exp_if(pv));
      end
    end
    if (state != ST_ACTIVE)
    begin
      host_model_inst.trig(8'h04);
      seq_walk(SQ_GO_ACTIVE, p0);
    end
    host_model_inst.reprog(IF_ALT, 4'h0, 8'h00);
    wt(4);
    chk(iface, IF_ALT);
    // Off beats on; then immediate shutdown beats both.
    host_model_inst.trig(8'h06);
    seq_walk(SQ_GO_STANDBY, p0);
    chk(state, ST_STANDBY);
    host_model_inst.trig(8'h04);
    seq_walk(SQ_GO_ACTIVE, p0);
    host_model_inst.trig(8'h07);
    seq_walk(SQ_SEVERE, p0);
    chk({p0.clocks_stopped, p0.switching_stopped}, 2'b11);
    chk(power, {3'b111, ALL_RAILS});
    wt(4);
    chk({state, rec_req}, {ST_RECOVERY, 1'b1});
    // Mid-run resets: immediate shutdown from standby, then an enabled current-limit
    // event after masked sleep requests are shown to be ignored in active.
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      wt(1);
      chk({state, power}, {ST_STANDBY, 3'b000, ALL_RAILS});
      if (k == 1)
      begin
        // Current-limit trigger enable and both sleep masks set.
        host_model_inst.wr(IDX_THERMAL_BUS, 8'h70);
        host_model_inst.trig(8'h04);
        seq_walk(SQ_GO_ACTIVE, p0);
        host_model_inst.trig(8'hc0);
        wt(6);
        chk({state, busy}, {ST_ACTIVE, 1'b0});
        host_model_inst.trig(8'h02);
        seq_walk(SQ_GO_STANDBY, p0);
      end
      host_model_inst.trig(k == 1 ? 8'h08 : 8'h01);
      seq_walk(SQ_SEVERE, p0);
      wt(4);
      chk({state, rec_req}, {ST_RECOVERY, 1'b1});
    end
    end_of_test();
  end
endmodule : pmic_default_state_sequencer_tb
`default_nettype wire
